// ===== logic/ofm_fmt_if.sv
// one output part travelling to the part formatter and back
interface ofm_fmt_if;
   import ofm_pkg::*;
   logic [SAMP_W-1:0]  partIn;
   logic [SCALE_W-1:0] scale;
   logic               signedMode;
   logic               wideMode;
   logic [PART_W-1:0]  partOut;
   modport ctl (output partIn, scale, signedMode, wideMode, input partOut);
   modport fmt (input partIn, scale, signedMode, wideMode, output partOut);
endinterface

// ===== logic/ofm_part_fmt.sv
// scales one 24-bit part into a 16-bit or 32-bit word
module ofm_part_fmt
   import ofm_pkg::*;
(
   ofm_fmt_if.fmt p
);
   logic [3:0]               sh;
   logic [PART_W-1:0]        ext;
   logic signed [PART_W-1:0] drop;

   always_comb begin
      // scale beyond eight would make the wide-mode left shift of eight minus scale negative, so it is clamped
      sh   = (p.scale > SCALE_MAX) ? SCALE_MAX[3:0] : p.scale[3:0];
      ext  = p.signedMode ? {{(PART_W-SAMP_W){p.partIn[SAMP_W-1]}}, p.partIn}
                          : {{(PART_W-SAMP_W){1'b0}}, p.partIn};
      drop = p.signedMode ? ($signed(ext) >>> sh) : $signed(ext >> sh);
      if (p.wideMode) begin
         p.partOut = ext << (SCALE_MAX[3:0] - sh);
      end else if (p.signedMode) begin
         if (drop > SMAX16) begin
            p.partOut = SMAX16;
         end else if (drop < SMIN16) begin
            p.partOut = SMIN16;
         end else begin
            p.partOut = drop;
         end
      end else begin
         p.partOut = (drop > $signed(UMAX16)) ? UMAX16 : drop;
      end
   end
endmodule

// ===== logic/ofm_pkg.sv
// constants, register map and types of the output formatter
package ofm_pkg;
   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int ADDR_W  = 16;
   localparam int CNT_W   = 12;
   localparam int SKIP_W  = 10;
   localparam int SCALE_W = 8;
   localparam int SAMP_W  = 24;
   localparam int PART_W  = 32;
   localparam int BANKS   = 4;
   localparam int LOG_W   = 4;
   localparam int PADDR_W = 8;
   localparam int BANK_LO = 14;
   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [PADDR_W-1:0] REG_START   = 8'h00;
   localparam logic [PADDR_W-1:0] REG_COUNT   = 8'h04;
   localparam logic [PADDR_W-1:0] REG_STRIDE  = 8'h08;
   localparam logic [PADDR_W-1:0] REG_ITOFS   = 8'h0c;
   localparam logic [PADDR_W-1:0] REG_SKIP    = 8'h10;
   localparam logic [PADDR_W-1:0] REG_FORMAT  = 8'h14;
   localparam logic [PADDR_W-1:0] REG_SCALE   = 8'h18;
   localparam logic [PADDR_W-1:0] REG_ITERS   = 8'h1c;
   localparam logic [PADDR_W-1:0] REG_CTRL    = 8'h20;
   localparam logic [PADDR_W-1:0] REG_CSTAT   = 8'h24;
   localparam logic [PADDR_W-1:0] REG_CMASK   = 8'h28;
   localparam logic [PADDR_W-1:0] REG_CCLR    = 8'h2c;
   localparam logic [PADDR_W-1:0] REG_ISTAT   = 8'h30;
   localparam logic [PADDR_W-1:0] REG_IMASK   = 8'h34;
   // ----------------------------------------------------------------
   // fields and values
   // ----------------------------------------------------------------
   localparam int FMT_REAL   = 0;
   localparam int FMT_WIDE   = 1;
   localparam int FMT_SIGNED = 2;
   localparam int FMT_CONJ   = 3;
   localparam int FMT_FFT    = 4;
   localparam int FMT_LOG_LO = 8;
   localparam int IRQ_DONE   = 0;
   localparam int IRQ_CONF   = 1;
   localparam int IRQ_W      = 2;
   localparam logic [ADDR_W-1:0]  OFS_MAX   = 16'h7fff;
   localparam logic [SCALE_W-1:0] SCALE_MAX = 8'h08;
   localparam logic [7:0]         BE_REAL16 = 8'h03;
   localparam logic [7:0]         BE_WORD32 = 8'h0f;
   localparam logic [7:0]         BE_CPLX32 = 8'hff;
   localparam logic signed [PART_W-1:0] SMAX16 = 32'sh00007fff;
   localparam logic signed [PART_W-1:0] SMIN16 = -32'sh00008000;
   localparam logic [PART_W-1:0]        UMAX16 = 32'h0000ffff;
   localparam logic [SAMP_W-1:0]        SMAX24 = 24'h7fffff;
   localparam logic [SAMP_W-1:0]        SMIN24 = 24'h800000;
   typedef enum logic {ST_IDLE, ST_RUN} ofm_state_t;
endpackage

// ===== logic/ofm_top.sv
// output formatter: stream in, scaled words out to local memory, apb registers
// ------------------------------------------------------------------------
// Behaviour
// - start address is a 16-bit byte address over all four banks
// - 12-bit count holds samples per iteration minus one
// - samples of one iteration are spaced by the byte stride, max 32767
// - each iteration starts one iteration offset after the last, max 32767
// - leading skip count drops the first samples of every iteration
// - real mode stores only the real part, else both parts
// - width bit picks 16-bit or 32-bit words per part
// - signed mode sign-extends and saturates signed, else unsigned
// - conjugate negates the imaginary part, complex output only
// - 8-bit scale sets the shift from 24 bits to the word
// - 16-bit drops scale lsbs and saturates; 32-bit extends and pads zeros
// - iteration count register sets how many iterations run
// - fft output in bit-reversed order lands in natural bin order
// - conflict status flags dma and accelerator on one bank, msb is bank zero
// - conflict mask bit suppresses that bank's indication
// - writing one to the clear register clears that bank's flag
// - one complex sample is accepted every clock while running
// ------------------------------------------------------------------------
module ofm_top
   import ofm_pkg::*;
#(
   parameter int ITER_W = 12
) (
   input  wire logic               sys_clk,
   input  wire logic               rst_b,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [PADDR_W-1:0] paddr,
   input  wire logic [31:0]        pwdata,
   output logic      [31:0]        prdata,
   output logic                    pready,
   output logic                    pslverr,
   input  wire logic               sampleValid,
   input  wire logic               sampleLast,
   input  wire logic [SAMP_W-1:0]  sampleI,
   input  wire logic [SAMP_W-1:0]  sampleQ,
   output logic                    sampleReady,
   output logic                    memWrEn,
   output logic      [ADDR_W-1:0]  memAddr,
   output logic      [63:0]        memWrData,
   output logic      [7:0]         memByteEn,
   input  wire logic [BANKS-1:0]   srcBankAccess,
   input  wire logic [BANKS-1:0]   dmaBankAccess,
   output logic                    irq
);
   // ---------------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------------
   logic [ADDR_W-1:0]  startAddr_r, stride_r, iterOfs_r;
   logic [CNT_W-1:0]   count_r;
   logic [SKIP_W-1:0]  skip_r;
   logic [15:0]        format_r;
   logic [SCALE_W-1:0] scale_r;
   logic [ITER_W-1:0]  iters_r;
   logic [BANKS-1:0]   cStat_r, cMask_r, cSet;
   logic [IRQ_W-1:0]   iStat_r, iMask_r, iSet;
   ofm_state_t         state_r;
   logic [CNT_W-1:0]   sampCnt_r, bin;
   logic [ITER_W-1:0]  iterCnt_r;
   logic [ADDR_W-1:0]  iterBase_r, wrAddr;
   logic [31:0]        rdData;
   logic               wrAcc, rdAcc, mapped, take, doWrite, lastIter, startReq;
   logic [SAMP_W-1:0]  qPart;
   logic [BANKS-1:0]   accelBank;
   logic [LOG_W-1:0]   fftLog;

   assign wrAcc    = psel & penable & pwrite;
   assign rdAcc    = psel & penable & ~pwrite;
   assign pready   = 1'b1;
   assign pslverr  = psel & penable & ~mapped;
   assign startReq = wrAcc & (paddr == REG_CTRL) & pwdata[0];
   assign fftLog   = format_r[FMT_LOG_LO +: LOG_W];

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         startAddr_r <= '0;
         count_r     <= '0;
         stride_r    <= '0;
         iterOfs_r   <= '0;
         skip_r      <= '0;
         format_r    <= '0;
         scale_r     <= '0;
         iters_r     <= '0;
         cMask_r     <= '0;
         iMask_r     <= '0;
      end else if (wrAcc) begin
         if (paddr == REG_START) begin
            startAddr_r <= pwdata[ADDR_W-1:0];
         end else if (paddr == REG_COUNT) begin
            count_r <= pwdata[CNT_W-1:0];
         end else if (paddr == REG_STRIDE) begin
            stride_r <= pwdata[ADDR_W-1:0] & OFS_MAX;
         end else if (paddr == REG_ITOFS) begin
            iterOfs_r <= pwdata[ADDR_W-1:0] & OFS_MAX;
         end else if (paddr == REG_SKIP) begin
            skip_r <= pwdata[SKIP_W-1:0];
         end else if (paddr == REG_FORMAT) begin
            format_r <= pwdata[15:0];
         end else if (paddr == REG_SCALE) begin
            scale_r <= pwdata[SCALE_W-1:0];
         end else if (paddr == REG_ITERS) begin
            iters_r <= pwdata[ITER_W-1:0];
         end else if (paddr == REG_CMASK) begin
            cMask_r <= pwdata[BANKS-1:0];
         end else if (paddr == REG_IMASK) begin
            iMask_r <= pwdata[IRQ_W-1:0];
         end
      end
   end

   // ---------------------------------------------------------------------
   // read mux
   // ---------------------------------------------------------------------
   always_comb begin
      rdData = '0;
      mapped = 1'b1;
      if (paddr == REG_START) begin
         rdData = 32'(startAddr_r);
      end else if (paddr == REG_COUNT) begin
         rdData = 32'(count_r);
      end else if (paddr == REG_STRIDE) begin
         rdData = 32'(stride_r);
      end else if (paddr == REG_ITOFS) begin
         rdData = 32'(iterOfs_r);
      end else if (paddr == REG_SKIP) begin
         rdData = 32'(skip_r);
      end else if (paddr == REG_FORMAT) begin
         rdData = 32'(format_r);
      end else if (paddr == REG_SCALE) begin
         rdData = 32'(scale_r);
      end else if (paddr == REG_ITERS) begin
         rdData = 32'(iters_r);
      end else if (paddr == REG_CTRL) begin
         rdData = 32'(state_r == ST_RUN);
      end else if (paddr == REG_CSTAT) begin
         rdData = 32'(cStat_r);
      end else if (paddr == REG_CMASK) begin
         rdData = 32'(cMask_r);
      end else if (paddr == REG_CCLR) begin
         rdData = '0;
      end else if (paddr == REG_ISTAT) begin
         rdData = 32'(iStat_r);
      end else if (paddr == REG_IMASK) begin
         rdData = 32'(iMask_r);
      end else begin
         mapped = 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         prdata <= '0;
      end else if (psel & ~penable & ~pwrite) begin
         prdata <= rdData;
      end
   end

   // ---------------------------------------------------------------------
   // sequencing
   // ---------------------------------------------------------------------
   // bit reversal is done in the address, so no reorder buffer is needed
   function automatic logic [CNT_W-1:0] bitRev(input logic [CNT_W-1:0] idx,
                                               input logic [LOG_W-1:0] n);
      logic [CNT_W-1:0] r;
      r = '0;
      for (int i = 0; i < CNT_W; i++) begin
         if (i < int'(n)) begin
            r[i] = idx[int'(n) - 1 - i];
         end
      end
      return r;
   endfunction

   assign sampleReady = (state_r == ST_RUN);
   assign take        = sampleValid & sampleReady;
   assign lastIter    = (iterCnt_r == iters_r);
   assign bin = format_r[FMT_FFT] ? bitRev(sampCnt_r, fftLog) : sampCnt_r;
   assign doWrite     = take & (bin >= CNT_W'(skip_r)) & (bin <= count_r);
   assign wrAddr      = iterBase_r + ADDR_W'(bin * stride_r);

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         state_r <= ST_IDLE;
      end else begin
         case (state_r)
            ST_IDLE: if (startReq) state_r <= ST_RUN;
            ST_RUN:  if (take & sampleLast & lastIter) state_r <= ST_IDLE;
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         sampCnt_r  <= '0;
         iterCnt_r  <= '0;
         iterBase_r <= '0;
      end else if (state_r == ST_IDLE) begin
         sampCnt_r  <= '0;
         iterCnt_r  <= '0;
         iterBase_r <= startAddr_r;
      end else if (take & sampleLast) begin
         sampCnt_r  <= '0;
         iterCnt_r  <= iterCnt_r + 1'b1;
         iterBase_r <= iterBase_r + iterOfs_r;
      end else if (take) begin
         sampCnt_r <= sampCnt_r + 1'b1;
      end
   end

   // ---------------------------------------------------------------------
   // formatting
   // ---------------------------------------------------------------------
   ofm_fmt_if fmtI ();
   ofm_fmt_if fmtQ ();

   // negating the most negative value would wrap, so it saturates instead
   always_comb begin
      if (format_r[FMT_CONJ] & ~format_r[FMT_REAL]) begin
         qPart = (sampleQ == SMIN24) ? SMAX24 : SAMP_W'(-sampleQ);
      end else begin
         qPart = sampleQ;
      end
   end

   assign fmtI.partIn     = sampleI;
   assign fmtQ.partIn     = qPart;
   assign fmtI.scale      = scale_r;
   assign fmtQ.scale      = scale_r;
   assign fmtI.signedMode = format_r[FMT_SIGNED];
   assign fmtQ.signedMode = format_r[FMT_SIGNED];
   assign fmtI.wideMode   = format_r[FMT_WIDE];
   assign fmtQ.wideMode   = format_r[FMT_WIDE];

   ofm_part_fmt uFmtI (.p(fmtI));
   ofm_part_fmt uFmtQ (.p(fmtQ));

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         memWrEn   <= 1'b0;
         memAddr   <= '0;
         memWrData <= '0;
         memByteEn <= '0;
      end else begin
         memWrEn <= doWrite;
         memAddr <= wrAddr;
         if (format_r[FMT_WIDE]) begin
            memWrData <= {fmtQ.partOut, fmtI.partOut};
            memByteEn <= format_r[FMT_REAL] ? BE_WORD32 : BE_CPLX32;
         end else begin
            memWrData <= {32'h00000000, fmtQ.partOut[15:0], fmtI.partOut[15:0]};
            memByteEn <= format_r[FMT_REAL] ? BE_REAL16 : BE_WORD32;
         end
      end
   end

   // ---------------------------------------------------------------------
   // conflicts and interrupts
   // ---------------------------------------------------------------------
   always_comb begin
      accelBank = srcBankAccess;
      if (memWrEn) begin
         accelBank[memAddr[ADDR_W-1:BANK_LO]] = 1'b1;
      end
      for (int b = 0; b < BANKS; b++) begin
         // msb of the status is bank zero
         cSet[BANKS-1-b] = dmaBankAccess[b] & accelBank[b] & ~cMask_r[BANKS-1-b];
      end
   end

   assign iSet = {|(cSet & ~cStat_r), take & sampleLast & lastIter};

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         cStat_r <= '0;
      end else if (wrAcc & (paddr == REG_CCLR)) begin
         cStat_r <= (cStat_r & ~pwdata[BANKS-1:0]) | cSet;
      end else begin
         cStat_r <= cStat_r | cSet;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         iStat_r <= '0;
      end else if (wrAcc & (paddr == REG_ISTAT)) begin
         iStat_r <= (iStat_r & ~pwdata[IRQ_W-1:0]) | iSet;
      end else begin
         iStat_r <= iStat_r | iSet;
      end
   end

   assign irq = |(iStat_r & iMask_r);

   // ---------------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   property p_write_addr;
      logic [ADDR_W-1:0] a;
      (doWrite, a = wrAddr) |=> memWrEn && memAddr == a;
   endproperty
   a_write_addr: assert property (p_write_addr) else $error("write address lost");

   property p_skip;
      take && bin < CNT_W'(skip_r) |=> !memWrEn;
   endproperty
   a_skip: assert property (p_skip) else $error("skipped sample written");

   property p_count;
      take && bin > count_r |=> !memWrEn;
   endproperty
   a_count: assert property (p_count) else $error("sample beyond count written");

   property p_real16;
      memWrEn && $past(format_r[FMT_REAL]) && !$past(format_r[FMT_WIDE])
         |-> memByteEn == BE_REAL16;
   endproperty
   a_real16: assert property (p_real16) else $error("real 16-bit enables wrong");

   property p_ready;
      state_r == ST_RUN && !(take && sampleLast && lastIter) |=> sampleReady;
   endproperty
   a_ready: assert property (p_ready) else $error("stream stalled while running");

   property p_iter_base;
      take && sampleLast && !lastIter |=> iterBase_r == $past(iterBase_r) + $past(iterOfs_r);
   endproperty
   a_iter_base: assert property (p_iter_base) else $error("iteration base wrong");

   property p_sticky;
      cStat_r[0] && !(wrAcc && paddr == REG_CCLR) |=> cStat_r[0];
   endproperty
   a_sticky: assert property (p_sticky) else $error("conflict flag dropped");

   property p_clear;
      wrAcc && paddr == REG_CCLR && pwdata[0] && !cSet[0] |=> !cStat_r[0];
   endproperty
   a_clear: assert property (p_clear) else $error("conflict flag not cleared");

   property p_mask;
      cMask_r[BANKS-1] && !cStat_r[BANKS-1] |=> !cStat_r[BANKS-1];
   endproperty
   a_mask: assert property (p_mask) else $error("masked bank flagged");

   sequence s_final;
      take && sampleLast && lastIter;
   endsequence
   property p_done;
      s_final |=> state_r == ST_IDLE && iStat_r[IRQ_DONE];
   endproperty
   a_done: assert property (p_done) else $error("run did not finish");
endmodule

// ===== tb/ofm_core_model.sv
// behavioural model of the core stream that feeds the output formatter
module ofm_core_model
   import ofm_pkg::*;
(
   input  wire logic              sys_clk,
   input  wire logic              rst_b,
   input  wire logic              go,
   input  wire logic              slow,
   input  wire logic [11:0]       len,
   input  wire logic [11:0]       iters,
   input  wire logic              sampleReady,
   output logic                   sampleValid,
   output logic                   sampleLast,
   output logic      [SAMP_W-1:0] sampleI,
   output logic      [SAMP_W-1:0] sampleQ
);
   // ---------------------------------------------------------------
   // one sample a clock, or one every other clock when slow
   // ---------------------------------------------------------------
   logic [15:0] lfsr_r;
   logic [15:0] mid;
   int          left_r;
   int          idx_r;
   function automatic logic [15:0] step(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   assign mid = step(lfsr_r);
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         lfsr_r <= 16'h004e;
         sampleValid <= 1'b0;
         sampleLast <= 1'b0;
         sampleI <= 24'h000000;
         sampleQ <= 24'h000000;
         left_r <= 0;
         idx_r <= 0;
      end else if (go) begin
         left_r <= len * (iters + 12'h001);
         idx_r <= 0;
      end else begin
         // released data is inverted so a stale value never passes as fresh
         if (sampleValid && sampleReady) begin
            sampleValid <= 1'b0;
            sampleLast <= 1'b0;
            sampleI <= ~sampleI;
            sampleQ <= ~sampleQ;
         end
         if (left_r != 0 && (!sampleValid || (sampleReady && !slow))) begin
            sampleValid <= 1'b1;
            sampleLast <= (idx_r == len - 1);
            sampleI <= {lfsr_r, lfsr_r[15:8]};
            sampleQ <= {mid, mid[7:0]};
            lfsr_r <= step(mid);
            idx_r <= (idx_r == len - 1) ? 0 : idx_r + 1;
            left_r <= left_r - 1;
         end
      end
   end
endmodule

// ===== tb/tb_top.sv
// self-checking bench of the output formatter
module tb_top
   import ofm_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct {logic [15:0] a; logic [63:0] d; logic [7:0] b;} ofm_exp_t;
   logic sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, lastErr;
   logic [7:0] paddr, memByteEn;
   logic [31:0] pwdata, prdata, cFmt, cScl, cSt, cCnt, cSkip, cStr, cOfs, iw, qw;
   logic sampleValid, sampleLast, sampleReady, memWrEn, irq, go, slow;
   logic [23:0] sampleI, sampleQ;
   logic [15:0] memAddr;
   logic [63:0] memWrData;
   logic [3:0] srcBankAccess, dmaBankAccess;
   logic [11:0] len, iters;
   ofm_exp_t expQ[$];
   ofm_exp_t e, g;
   int errors, compares, idx, it, bin, cyc, stalls;
   ofm_top #(.ITER_W(12)) dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sampleValid(sampleValid), .sampleLast(sampleLast),
      .sampleI(sampleI), .sampleQ(sampleQ), .sampleReady(sampleReady), .memWrEn(memWrEn),
      .memAddr(memAddr), .memWrData(memWrData), .memByteEn(memByteEn),
      .srcBankAccess(srcBankAccess), .dmaBankAccess(dmaBankAccess), .irq(irq));
   ofm_core_model core_u (.sys_clk(sys_clk), .rst_b(rst_b), .go(go), .slow(slow), .len(len),
      .iters(iters), .sampleReady(sampleReady), .sampleValid(sampleValid),
      .sampleLast(sampleLast), .sampleI(sampleI), .sampleQ(sampleQ));
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      r = prdata;
      lastErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      apb(1'b1, a, d, r);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      logic [31:0] r;
      apb(1'b0, a, 32'h0, r);
      check(64'(r), 64'(x));
   endtask
   task automatic hit(input logic [3:0] s, input logic [3:0] d);
      srcBankAccess <= s;
      dmaBankAccess <= d;
      @(posedge sys_clk);
      srcBankAccess <= 4'h0;
      dmaBankAccess <= 4'h0;
      @(posedge sys_clk);
   endtask
   function automatic logic [31:0] fmtp(input logic [23:0] x);
      logic signed [31:0] v;
      v = cFmt[FMT_SIGNED] ? {{8{x[23]}}, x} : {8'h00, x};
      if (cFmt[FMT_WIDE]) return v <<< (8 - cScl);
      v = cFmt[FMT_SIGNED] ? v >>> cScl : v >> cScl;
      if (cFmt[FMT_SIGNED] && v > SMAX16) v = SMAX16;
      if (cFmt[FMT_SIGNED] && v < SMIN16) v = SMIN16;
      if (!cFmt[FMT_SIGNED] && v > UMAX16) v = UMAX16;
      return {16'h0000, v[15:0]};
   endfunction
   function automatic int br(input int i, input int n);
      br = 0;
      for (int k = 0; k < n; k++) br = (br << 1) | ((i >> k) & 1);
   endfunction
   function automatic logic [63:0] msk(input logic [7:0] b);
      for (int k = 0; k < 8; k++) msk[8*k +: 8] = {8{b[k]}};
   endfunction
   task automatic run(input logic [31:0] f, s, st, cn, sk, sr, of, its, ln, input logic sl);
      logic [31:0] r;
      cFmt = f; cScl = s; cSt = st; cCnt = cn; cSkip = sk; cStr = sr; cOfs = of;
      idx = 0;
      it = 0;
      wr(REG_FORMAT, f); wr(REG_SCALE, s); wr(REG_START, st); wr(REG_COUNT, cn);
      wr(REG_SKIP, sk); wr(REG_STRIDE, sr); wr(REG_ITOFS, of); wr(REG_ITERS, its);
      slow <= sl;
      len <= ln[11:0];
      iters <= its[11:0];
      wr(REG_CTRL, 32'h1);
      go <= 1'b1;
      @(posedge sys_clk);
      go <= 1'b0;
      r = 32'h0;
      while (r[IRQ_DONE] !== 1'b1) apb(1'b0, REG_ISTAT, 32'h0, r);
      repeat (3) @(posedge sys_clk);
      check(64'(expQ.size()), 64'h0);
      check(64'(stalls), 64'h0);
      wr(REG_ISTAT, 32'h1);
   endtask
   // ---------------------------------------------------------------
   // expectation at every accepted sample inside the skip and count window, comparison at every write
   // ---------------------------------------------------------------
   always @(negedge sys_clk) begin
      if (rst_b && sampleValid && !sampleReady) stalls++;
      if (rst_b && sampleValid && sampleReady) begin
         bin = cFmt[FMT_FFT] ? br(idx, int'(cFmt[11:8])) : idx;
         if (bin >= cSkip && bin <= cCnt) begin
            iw = fmtp(sampleI);
            qw = fmtp(cFmt[FMT_CONJ] ? ((sampleQ == SMIN24) ? SMAX24 : -sampleQ) : sampleQ);
            e.a = 16'(cSt + it * cOfs + bin * cStr);
            e.b = cFmt[FMT_REAL] ? (cFmt[FMT_WIDE] ? BE_WORD32 : BE_REAL16)
                                 : (cFmt[FMT_WIDE] ? BE_CPLX32 : BE_WORD32);
            e.d = cFmt[FMT_WIDE] ? {qw, iw} : {32'h0, qw[15:0], iw[15:0]};
            expQ.push_back(e);
         end
         if (sampleLast) begin
            idx = 0;
            it++;
         end else idx++;
      end
   end
   always @(negedge sys_clk) begin
      if (rst_b && memWrEn === 1'b1) begin
         if (expQ.size() == 0) check(64'h1, 64'h0);
         else begin
            g = expQ.pop_front();
            check(64'(memAddr), 64'(g.a));
            check(memWrData & msk(g.b), g.d & msk(g.b));
            check(64'(memByteEn), 64'(g.b));
         end
      end
   end
   // a hang counts as a mismatch; the whole run needs a few hundred cycles
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         finish_test();
      end
   end
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   logic [7:0]  regA [13] = '{REG_START, REG_COUNT, REG_STRIDE, REG_ITOFS, REG_SKIP,
      REG_FORMAT, REG_SCALE, REG_ITERS, REG_CSTAT, REG_CMASK, REG_CCLR, REG_ISTAT, REG_IMASK};
   logic [31:0] regM [13] = '{32'hffff, 32'hfff, 32'h7fff, 32'h7fff, 32'h3ff, 32'hffff,
      32'hff, 32'hfff, 32'h0, 32'hf, 32'h0, 32'h0, 32'h3};
   initial begin
      {rst_b, psel, penable, pwrite, go, slow} = '0;
      paddr = '0; pwdata = '0; srcBankAccess = '0; dmaBankAccess = '0; len = '0; iters = '0;
      repeat (10) @(posedge sys_clk);
      rst_b <= 1'b1;
      @(posedge sys_clk);
      for (int k = 0; k < 13; k++) begin
         rd(regA[k], 32'h0);
         wr(regA[k], 32'hffffffff);
         rd(regA[k], regM[k]);
         wr(regA[k], 32'h0);
      end
      wr(8'h38, 32'hffffffff);
      rd(8'hfc, 32'h0);
      check(64'(lastErr), 64'h1);
      hit(4'h0, 4'hf);
      rd(REG_CSTAT, 32'h0);
      // source and dma hit the same bank in each step, so that bank's flag is set
      for (int b = 0; b < 4; b++) begin
         hit(4'(1 << b), 4'(1 << b));
         rd(REG_CSTAT, 32'(8 >> b));
         rd(REG_CSTAT, 32'(8 >> b));
         wr(REG_CCLR, 32'(8 >> b));
         rd(REG_CSTAT, 32'h0);
      end
      wr(REG_CMASK, 32'h8);
      hit(4'h1, 4'h1);
      rd(REG_CSTAT, 32'h0);
      wr(REG_CMASK, 32'h0);
      rd(REG_ISTAT, 32'h2);
      check(64'(irq), 64'h0);
      wr(REG_IMASK, 32'h2);
      check(64'(irq), 64'h1);
      wr(REG_ISTAT, 32'h2);
      check(64'(irq), 64'h0);
      // dma sits on the destination bank during the first run, so writes collide
      dmaBankAccess <= 4'h8;
      run(32'h0c, 3, 32'hc040, 5, 2, 8, 32'h100, 1, 8, 1'b1);
      dmaBankAccess <= 4'h0;
      rd(REG_CSTAT, 32'h1);
      wr(REG_CCLR, 32'h1);
      run(32'h313, 0, 32'h3ff0, 6, 1, 4, 32'h20, 2, 8, 1'b0);
      run(32'h06, 8, 32'hfff8, 3, 0, 32'h7fff, 32'h7fff, 1, 4, 1'b0);
      run(32'h00, 0, 32'h0100, 2, 0, 4, 0, 0, 3, 1'b0);
      finish_test();
   end
endmodule
